// File: hdl/gro_angle_acc.sv
`timescale 1ns/1ps
// Sums rate samples over one processing cycle into a delta angle
module gro_angle_acc (
   input wire logic sys_clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   gro_axis_if.acc link // Sample path
);
   logic signed [47:0] sum_ff, nxt_sum;
   logic signed [15:0] angle_ff, nxt_angle;
   logic signed [47:0] total;
   logic signed [47:0] quot;

   // Sum includes this cycle's sample so none is dropped at the boundary
   always_comb begin
      total = sum_ff + (link.sampleValid ? 48'(link.rateIn) : 48'h0);
      // Mean over the cycle, so one count is KG*(dec+1)/fs degrees
      quot = total / signed'(48'(link.divisor));
      nxt_sum = sum_ff;
      nxt_angle = angle_ff;
      if (link.cycleDone) begin
         // Rate in 32-bit form, one LSB is KG/2^16 deg/s; divide by
         // sample rate is implied: one count per sample equals KG/f deg
         nxt_angle = quot[47:32] == {16{quot[31]}} ? quot[31:16]
            : (quot[47] ? 16'sh8000 : 16'sh7fff);
         nxt_sum = 48'h0;
      end else begin
         nxt_sum = total;
      end
   end

   // Saturation avoids wrap to the opposite sign on fast spins
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sum_ff <= 48'h0;
         angle_ff <= 16'h0;
      end else begin
         sum_ff <= nxt_sum;
         angle_ff <= nxt_angle;
      end
   end
   assign link.angleOut = angle_ff;
endmodule // gro_angle_acc

// File: hdl/gro_axis_if.sv
`timescale 1ns/1ps
// Per-axis sample path between the top and the accumulator
interface gro_axis_if;
   logic sampleValid;
   logic cycleDone;
   logic signed [31:0] rateIn;
   logic signed [15:0] angleOut;
   logic [16:0] divisor;
   modport src (output sampleValid, output cycleDone, output rateIn,
      output divisor, input angleOut);
   modport acc (input sampleValid, input cycleDone, input rateIn,
      input divisor, output angleOut);
endinterface

// File: hdl/gro_pkg.sv
package gro_pkg;
   // Register addresses, byte address of the lower byte
   localparam logic [6:0] ADDR_X_RATE_LOW = 7'h04;
   localparam logic [6:0] ADDR_X_RATE_HIGH = 7'h06;
   localparam logic [6:0] ADDR_Y_RATE_LOW = 7'h08;
   localparam logic [6:0] ADDR_Y_RATE_HIGH = 7'h0a;
   localparam logic [6:0] ADDR_Z_RATE_LOW = 7'h0c;
   localparam logic [6:0] ADDR_Z_RATE_HIGH = 7'h0e;
   localparam logic [6:0] ADDR_X_ANGLE = 7'h24;
   localparam logic [6:0] ADDR_Y_ANGLE = 7'h26;
   localparam logic [6:0] ADDR_Z_ANGLE = 7'h28;
   localparam logic [6:0] ADDR_MISC_CONTROL = 7'h32;
   localparam logic [6:0] ADDR_DECIMATION = 7'h36;
   // Control reset values
   localparam logic [15:0] MISC_CONTROL_RST = 16'h00c1;
   localparam logic [15:0] DECIMATION_RST = 16'h0000;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   // Sample clock select field in the misc control word
   localparam int CLK_SEL_LSB = 2;
   localparam logic [1:0] CLK_SEL_INTERNAL = 2'h0;
   localparam int INTERNAL_RATE_HZ = 2048;
   localparam int NUM_AXES = 3;
   localparam int WORD_W = 16;
   // Accumulator extra bits beyond the 16-bit rate word
   localparam int FRAC_W = 16;
endpackage

// File: hdl/gro_rate_outputs.sv
`timescale 1ns/1ps
// Summary of operation
// - Primary rate word is 16-bit two's complement, 0.005 deg/s per count.
// - Secondary word per axis holds filter bit growth low bits.
// - Primary and secondary form one 32-bit value, primary on top.
// - Exactly two rate words per axis, six in total.
// - Each axis has a word of displacement per processing cycle.
// - Delta-angle words are 16-bit two's complement, zero reads zero.
// - One angle count is scale times (decimation+1) over sample rate.
// - Clock select 00 means 2048 Hz internal, else external rate.
// - Rate words read-only at 0x04..0x0E, low then high per axis.
// - Delta-angle words read-only at 0x24, 0x26, 0x28.
// - Secondary word is the lower half, primary the upper half.
// - Decimation comes from the decimation register, reset zero.
module gro_rate_outputs #(
   parameter int DEC_W = 11 // Width of the decimation count
) (
   input wire logic sys_clk, // 25 MHz system clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic sampleStrobe, // Internal 2048 Hz sample tick
   input wire logic extSampleStrobe, // External sample clock tick
   input wire logic [95:0] filterRate, // Filtered rates z,y,x 32b each
   input wire logic [6:0] regAddr, // Register byte address
   input wire logic regRead, // Read strobe
   input wire logic regWrite, // Write strobe
   input wire logic [15:0] regWdata, // Write data
   output logic [15:0] regRdata, // Read data, registered
   output logic regAck, // Read or write answered
   output logic dataReady // Pulse when new outputs stand
);
   initial begin
      if (DEC_W < 1 || DEC_W > 16)
         $error("DEC_W must be 1..16");
   end

   logic [15:0] misc_ff, nxt_misc;
   logic [15:0] dec_ff, nxt_dec;
   logic [DEC_W-1:0] decCnt_ff, nxt_decCnt;
   logic [31:0] rate_ff [gro_pkg::NUM_AXES];
   logic [31:0] nxt_rate [gro_pkg::NUM_AXES];
   logic [15:0] rdata_ff, nxt_rdata;
   logic ack_ff, nxt_ack, rdy_ff, nxt_rdy;
   logic tick, cycleDone;
   logic [15:0] angle [gro_pkg::NUM_AXES];

   // Sample source follows the clock select field
   assign tick = (misc_ff[gro_pkg::CLK_SEL_LSB +: 2] ==
      gro_pkg::CLK_SEL_INTERNAL) ? sampleStrobe : extSampleStrobe;
   // Cycle ends every decimation+1 samples
   assign cycleDone = tick &&
      (decCnt_ff >= dec_ff[DEC_W-1:0]);

   // One accumulator per axis; counts scale as KG*(dec+1)/fs
   generate
      for (genvar a = 0; a < gro_pkg::NUM_AXES; a++) begin : g_axis
         gro_axis_if ax ();
         assign ax.sampleValid = tick;
         assign ax.cycleDone = cycleDone;
         // Samples per cycle, decimation plus one
         assign ax.divisor = 17'(dec_ff[DEC_W-1:0]) + 17'h1;
         assign ax.rateIn = signed'(filterRate[a*32 +: 32]);
         assign angle[a] = ax.angleOut;
         gro_angle_acc u_acc (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .link(ax)
         );
      end
   endgenerate

   // Address decode shared by the read path
   function automatic logic [15:0] readWord(input logic [6:0] addr);
      unique case (addr)
         gro_pkg::ADDR_X_RATE_LOW: readWord = rate_ff[0][15:0];
         gro_pkg::ADDR_X_RATE_HIGH: readWord = rate_ff[0][31:16];
         gro_pkg::ADDR_Y_RATE_LOW: readWord = rate_ff[1][15:0];
         gro_pkg::ADDR_Y_RATE_HIGH: readWord = rate_ff[1][31:16];
         gro_pkg::ADDR_Z_RATE_LOW: readWord = rate_ff[2][15:0];
         gro_pkg::ADDR_Z_RATE_HIGH: readWord = rate_ff[2][31:16];
         gro_pkg::ADDR_X_ANGLE: readWord = angle[0];
         gro_pkg::ADDR_Y_ANGLE: readWord = angle[1];
         gro_pkg::ADDR_Z_ANGLE: readWord = angle[2];
         gro_pkg::ADDR_MISC_CONTROL: readWord = misc_ff;
         gro_pkg::ADDR_DECIMATION: readWord = dec_ff;
         default: readWord = gro_pkg::WORD_ZERO;
      endcase
   endfunction

   // Register access and the processing-cycle counter
   always_comb begin
      nxt_misc = misc_ff;
      nxt_dec = dec_ff;
      nxt_decCnt = decCnt_ff;
      nxt_rdata = rdata_ff;
      nxt_ack = regRead || regWrite;
      nxt_rdy = cycleDone;
      // Output words are read-only; writes there are ignored
      if (regWrite && regAddr == gro_pkg::ADDR_MISC_CONTROL)
         nxt_misc = regWdata;
      if (regWrite && regAddr == gro_pkg::ADDR_DECIMATION)
         nxt_dec = regWdata;
      if (regRead)
         nxt_rdata = readWord(regAddr);
      if (cycleDone)
         nxt_decCnt = '0;
      else if (tick)
         nxt_decCnt = decCnt_ff + 1'b1;
      for (int a = 0; a < gro_pkg::NUM_AXES; a++) begin
         nxt_rate[a] = rate_ff[a];
         // Whole 32 bits latched at once so halves always match
         if (cycleDone)
            nxt_rate[a] = filterRate[a*32 +: 32];
      end
   end

   // Rate registers hold the primary word on top, growth below
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         misc_ff <= gro_pkg::MISC_CONTROL_RST;
         dec_ff <= gro_pkg::DECIMATION_RST;
         decCnt_ff <= '0;
         rdata_ff <= gro_pkg::WORD_ZERO;
         ack_ff <= 1'b0;
         rdy_ff <= 1'b0;
         for (int a = 0; a < gro_pkg::NUM_AXES; a++)
            rate_ff[a] <= 32'h0;
      end else begin
         misc_ff <= nxt_misc;
         dec_ff <= nxt_dec;
         decCnt_ff <= nxt_decCnt;
         rdata_ff <= nxt_rdata;
         ack_ff <= nxt_ack;
         rdy_ff <= nxt_rdy;
         for (int a = 0; a < gro_pkg::NUM_AXES; a++)
            rate_ff[a] <= nxt_rate[a];
      end
   end

   assign regRdata = rdata_ff;
   assign regAck = ack_ff;
   assign dataReady = rdy_ff;
endmodule // gro_rate_outputs

// File: sim/gro_host_model.sv
`timescale 1ns/1ps
// Host side of the register port, one transfer at a time
module gro_host_model (
   input wire logic sys_clk, // Clock
   input wire logic [15:0] regRdata, // Read data
   input wire logic regAck, // Answer
   output logic [6:0] regAddr, // Address
   output logic regRead, // Read
   output logic regWrite, // Write
   output logic [15:0] regWdata // Write data
);
   initial {regAddr, regRead, regWrite, regWdata} = 25'h0;
   // Held to the answer edge; extra edge drains the repeat answer
   task automatic xfer(input logic w, input logic [6:0] a,
      input logic [15:0] d, output logic [15:0] q);
      @(posedge sys_clk);
      {regAddr, regRead, regWrite, regWdata} <= {a, !w, w, d};
      repeat (2) @(posedge sys_clk);
      q = regRdata; // All 16 bits kept, LSB weight set by width
      {regRead, regWrite, regWdata} <= {2'h0, ~d};
      @(posedge sys_clk);
   endtask
endmodule // gro_host_model

// File: sim/gro_rate_outputs_bench.sv
`timescale 1ns/1ps
// Drives sample ticks and register reads, judges the words returned
module gro_rate_outputs_bench;
   logic sys_clk = 1'b0, sys_rst = 1'b1;
   logic sampleStrobe = 1'b0, extSampleStrobe = 1'b0;
   logic [95:0] filterRate = 96'h0;
   logic [6:0] regAddr;
   logic regRead, regWrite, regAck, dataReady;
   logic [15:0] regWdata, regRdata, q;
   int mismatches = 0, comparisons = 0;
   always #20 sys_clk = ~sys_clk;
   gro_rate_outputs #(.DEC_W(11)) dut_u (.*);
   gro_host_model hostU (.*);
   // Read one word through the host and compare it
   task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
      hostU.xfer(1'b0, a, 16'h0000, q);
      comparisons++;
      mismatches += (q !== e);
      if (q !== e) $display("[ERR] %0t at %h got %h want %h", $time, a, q, e);
   endtask
   task automatic tick(input logic ext, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         {extSampleStrobe, sampleStrobe} <= {ext, !ext};
         @(posedge sys_clk);
         {extSampleStrobe, sampleStrobe} <= 2'h0;
      end
   endtask
   task automatic t_rates();
      rdchk(7'h32, 16'h00c1);
      rdchk(7'h36, 16'h0000);
      rdchk(7'h20, 16'h0000);
      filterRate <= {32'hfffffffe, 32'hb1e08001, 32'h4e200123};
      tick(1'b0, 1);
      hostU.xfer(1'b1, 7'h06, 16'h1234, q);
      for (int i = 0; i < 3; i++) begin
         rdchk(7'h04 + 7'(i * 4), filterRate[i * 32 +: 16]);
         rdchk(7'h06 + 7'(i * 4), filterRate[i * 32 + 16 +: 16]);
         rdchk(7'h24 + 7'(i * 2), filterRate[i * 32 + 16 +: 16]);
      end
      $display("rate test done");
   endtask
   // Ignored internal ticks, then two external ticks with decimation 1
   task automatic t_decim();
      hostU.xfer(1'b1, 7'h32, 16'h00c5, q);
      hostU.xfer(1'b1, 7'h36, 16'h0001, q);
      filterRate <= {32'hfffe0000, 32'h00020000, 32'h7fff0000};
      tick(1'b0, 3);
      rdchk(7'h24, 16'h4e20);
      tick(1'b1, 2);
      rdchk(7'h24, 16'h7fff);
      rdchk(7'h26, 16'h0002);
      rdchk(7'h28, 16'hfffe);
      $display("decimation test done");
   endtask
   task automatic complete_run(input int extra);
      mismatches += extra;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Tests need about a hundred cycles; a hang ends as a mismatch
   initial #400000 complete_run(1);
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_rates();
      t_decim();
      complete_run(0);
   end
endmodule // gro_rate_outputs_bench

// File: sim/gro_rate_outputs_properties.sv
`timescale 1ns/1ps
// Register answer and data-ready timing seen at the block's pins
module gro_rate_checker (
   input wire logic sys_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic sampleStrobe, // Tick
   input wire logic extSampleStrobe, // External tick
   input wire logic [6:0] regAddr, // Address
   input wire logic regRead, // Read
   input wire logic regWrite, // Write
   input wire logic [15:0] regRdata, // Read data
   input wire logic regAck, // Answer
   input wire logic dataReady // New outputs
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_b2b; regRead ##1 regRead; endsequence
   property p_ack; regRead || regWrite |=> regAck; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_quiet; !(regRead || regWrite) |=> !regAck; endproperty
   a_quiet: assert property (p_quiet) else $error("stray ack");
   property p_b2b; s_b2b |-> regAck ##1 regAck; endproperty
   a_b2b: assert property (p_b2b) else $error("lost ack");
   property p_hold; !(regRead || regWrite) |=> $stable(regRdata); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_wr; regWrite && !regRead |=> $stable(regRdata); endproperty
   a_wr: assert property (p_wr) else $error("write moved data");
   property p_gap; regRead && regAddr == 7'h20 |=> regRdata == 16'h0000; endproperty
   a_gap: assert property (p_gap) else $error("unmapped nonzero");
   property p_pulse; dataReady |=> !dataReady; endproperty
   a_pulse: assert property (p_pulse) else $error("long ready");
   property p_cause;
      dataReady |-> $past(sampleStrobe, 1) || $past(extSampleStrobe, 1);
   endproperty
   a_cause: assert property (p_cause) else $error("ready no tick");
endmodule // gro_rate_checker
bind gro_rate_outputs gro_rate_checker chkU (.*);
